/* inc/charge_ctrl_map.vh */
// Constants for the cell charge supervisory logic
`ifndef CHARGE_CTRL_MAP_VH
`define CHARGE_CTRL_MAP_VH

// Timebase
`define CLK_MHZ          250
`define TICK_US          1000
`define TICK_CYCLES      (`TICK_US * `CLK_MHZ)
`define DEBOUNCE_MS      32
`define TEST_WIDTH_MS    256
`define TEST_PERIOD_S    64
`define TEST_PERIOD_MS   (`TEST_PERIOD_S * 1000)

// Charge states
`define ST_IDLE          2'h0
`define ST_PRECHARGE     2'h1
`define ST_FULL          2'h2
`define ST_TRICKLE       2'h3

// Charge drive codes
`define DRV_OFF          2'h0
`define DRV_PRECHARGE    2'h1
`define DRV_FULL         2'h2
`define DRV_CLAMP        2'h3

// Register port
`define ADDR_STATUS      2'h0
`define ADDR_CONTROL     2'h1
`define CTRL_RESET       8'h01
`define CTRL_TEST_EN     0
`define STAT_STATE_LO    0
`define STAT_CHARGER     2
`define STAT_HIB         3
`define STAT_TEST        4
`define STAT_LOAD        5
`define STAT_INHIBIT     6

`endif

/* src/ms_timebase.v */
// Divider giving a one-cycle tick every millisecond
`timescale 1ns/1ps
module ms_timebase #(
  parameter TICK_CYCLES = 250000
) (
  // Clock and reset
  input  wire i_sys_clk,
  input  wire i_sys_rst,
  // Tick
  output reg  o_tick
);
  reg [31:0] count;

  always @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      count  <= 32'h0;
      o_tick <= 1'b0;
    end else if (count >= TICK_CYCLES - 1) begin
      count  <= 32'h0;
      o_tick <= 1'b1;
    end else begin
      count  <= count + 32'h1;
      o_tick <= 1'b0;
    end
  end
endmodule // ms_timebase

/* src/level_debounce.v */
// Level debouncer: output follows input only after it has held for COUNT ticks
`timescale 1ns/1ps
module level_debounce #(
  parameter COUNT = 32
) (
  // Clock and reset
  input  wire i_sys_clk,
  input  wire i_sys_rst,
  input  wire i_clear,
  input  wire i_tick,
  // Level
  input  wire i_level,
  output reg  o_level
);
  reg [15:0] held;

  always @(posedge i_sys_clk) begin
    if (i_sys_rst || i_clear) begin
      held    <= 16'h0;
      o_level <= 1'b0;
    end else if (i_level == o_level) begin
      held <= 16'h0;
    end else if (i_tick) begin
      if (held >= COUNT - 1) begin
        held    <= 16'h0;
        o_level <= i_level;
      end else begin
        held <= held + 16'h1;
      end
    end
  end
endmodule // level_debounce

/* src/li_ion_charge_control_logic.v */
// Supervisory logic of a single-cell charge and protection controller
//
// Contract
// R1: Inhibit high switches charge drive off
// R2: Inhibit falling edge resets charge state machine
// R3: Chemistry input selects low or high termination
// R4: Hibernate request held 32 ms latches load open
// R5: Hibernate exit low pulse clears latch
// R6: Charger detection only with battery present low
// R7: Qualified charger starts charging, sets detect output
// R8: Detect output low while charger seen, else released
// R9: Phase flag low full-rate, released trickle
// R10: Phase flag released while charging inhibited
// R11: Phone power allowed: above phone-on, charger, battery
// R12: Modes precharge, full-rate, trickle from thresholds
// R13: Full-rate saturates pass, trickle clamps termination
// R14: Excess dissipation reduces drive further
// R15: Test pulses 256 ms every 64 s
// R16: Test pulse requests full current, clamped
// R17: Load switch opens on overload or undervoltage
// R18: Charger connect and disconnect debounced 32 ms
// R19: Pulses only above phone-on, re-evaluate at end
// R20: Counters from one timebase, cleared on reset
//
// The implementer's own choices: the address map and the strobed register port.
`timescale 1ns/1ps
`include "charge_ctrl_map.vh"
module li_ion_charge_control_logic #(
  parameter TICK_CYCLES    = `TICK_CYCLES,
  parameter DEBOUNCE_MS    = `DEBOUNCE_MS,
  parameter TEST_WIDTH_MS  = `TEST_WIDTH_MS,
  parameter TEST_PERIOD_MS = `TEST_PERIOD_MS
) (
  // Clock and reset
  input  wire       i_sys_clk,
  input  wire       i_sys_rst,
  // Phone control pins
  input  wire       i_charge_inhibit,
  input  wire       i_chemistry_select,
  input  wire       i_hibernate_request,
  input  wire       i_hibernate_exit_n,
  input  wire       i_battery_present_n,
  // Analog comparator results
  input  wire       i_charger_sense,
  input  wire       i_cell_above_precharge,
  input  wire       i_cell_above_phone_on,
  input  wire       i_cell_above_charge_low,
  input  wire       i_cell_at_term_low,
  input  wire       i_cell_at_term_high,
  input  wire       i_excess_power,
  input  wire       i_pass_unsat,
  input  wire       i_load_overload,
  // Charge drive to the analog loops and the load switch
  output reg  [1:0] o_charge_drive,
  output reg        o_drive_reduce,
  output reg        o_term_high_level,
  output reg        o_test_pulse,
  output reg        o_load_switch_on,
  // Status pins to the phone
  output reg        o_charger_seen_out,
  output reg        o_charger_seen_out_oe,
  output reg        o_charge_phase_flag,
  output reg        o_charge_phase_flag_oe,
  output reg        o_phone_power_allow,
  // Register port
  input  wire [1:0] i_addr,
  input  wire [7:0] i_wr_data,
  input  wire       i_wr,
  input  wire       i_rd,
  output reg  [7:0] o_rd_data
);
  ////////////////////////////////////////////////////////////////////////////
  // Timebase and debouncers
  wire       tick;
  wire       charger_db;
  wire       hib_db;
  reg        inhibit_q;
  reg  [1:0] state;
  reg  [1:0] next_state;
  reg  [7:0] control;
  reg        hib_latch;
  reg  [15:0] period_cnt;
  wire       sm_reset;
  wire       charger_seen;
  wire       charging;
  wire       test_active;
  wire       test_end;
  wire       at_term;
  wire       inhibit_fall;
  wire       load_fault;
  wire       test_allowed;
  wire       supply_ok;
  wire       charge_full;
  wire       ctrl_write;
  reg  [7:0] status_word;

  // Inhibit release restarts from idle, so does a lost charger
  assign inhibit_fall = inhibit_q && !i_charge_inhibit; // [R2]
  assign sm_reset     = inhibit_fall || !charger_seen; // [R2] [R20]

  // One millisecond tick drives every slow counter
  ms_timebase #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_timebase (
    .i_sys_clk (i_sys_clk),
    .i_sys_rst (i_sys_rst),
    .o_tick    (tick)
  ); // [R20]

  // An absent battery holds the charger debouncer cleared
  level_debounce #(
    .COUNT (DEBOUNCE_MS)
  ) u_charger_db (
    .i_sys_clk (i_sys_clk),
    .i_sys_rst (i_sys_rst),
    .i_clear   (i_battery_present_n),
    .i_tick    (tick),
    .i_level   (i_charger_sense),
    .o_level   (charger_db)
  ); // [R18]

  level_debounce #(
    .COUNT (DEBOUNCE_MS)
  ) u_hib_db (
    .i_sys_clk (i_sys_clk),
    .i_sys_rst (i_sys_rst),
    .i_clear   (1'b0),
    .i_tick    (tick),
    .i_level   (i_hibernate_request),
    .o_level   (hib_db)
  ); // [R4]

  assign charger_seen = charger_db && !i_battery_present_n; // [R6]
  assign at_term      = i_chemistry_select ? i_cell_at_term_high : i_cell_at_term_low; // [R3]
  assign charging     = (state == `ST_FULL) || (state == `ST_TRICKLE);
  assign load_fault   = i_load_overload || !i_cell_above_charge_low; // [R17]
  assign supply_ok    = !i_pass_unsat && !at_term; // [R16]
  assign charge_full  = (state == `ST_FULL) && !i_charge_inhibit; // [R9] [R10]
  assign ctrl_write   = i_wr && (i_addr == `ADDR_CONTROL);

  ////////////////////////////////////////////////////////////////////////////
  // Test pulse counter
  // Pulses only while charging above the phone-on level and enabled by software
  assign test_allowed = charging && i_cell_above_phone_on && control[`CTRL_TEST_EN]; // [R19]
  assign test_active  = test_allowed && (period_cnt < TEST_WIDTH_MS); // [R15] [R19]
  assign test_end    = o_test_pulse && !test_active;

  always @(posedge i_sys_clk) begin
    if (i_sys_rst || sm_reset || !charging) begin
      period_cnt <= 16'h0; // [R20]
    end else if (tick) begin
      if (period_cnt >= TEST_PERIOD_MS - 1) begin
        period_cnt <= 16'h0; // [R15]
      end else begin
        period_cnt <= period_cnt + 16'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Charge mode state machine
  always @* begin
    next_state = state;
    case (state)
      `ST_IDLE: begin
        if (charger_seen && !i_charge_inhibit) begin
          next_state = i_cell_above_precharge ? `ST_FULL : `ST_PRECHARGE; // [R7] [R12]
        end
      end
      `ST_PRECHARGE: begin
        if (i_cell_above_precharge) begin
          next_state = `ST_FULL; // [R12]
        end
      end
      `ST_FULL: begin
        if (at_term && !o_test_pulse) begin
          next_state = `ST_TRICKLE; // [R12]
        end
      end
      `ST_TRICKLE: begin
        if (test_end && supply_ok) begin
          next_state = `ST_FULL; // [R16] [R19]
        end
      end
      default: begin
        next_state = `ST_IDLE;
      end
    endcase
  end

  always @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      state     <= `ST_IDLE;
      inhibit_q <= 1'b0;
    end else begin
      inhibit_q <= i_charge_inhibit;
      if (sm_reset || i_charge_inhibit) begin
        state <= `ST_IDLE; // [R1] [R2]
      end else begin
        state <= next_state;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Hibernate latch, set wins over clear
  always @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      hib_latch <= 1'b0;
    end else if (hib_db) begin
      // A debounced request that still stands beats an exit pulse
      hib_latch <= 1'b1; // [R4]
    end else if (!i_hibernate_exit_n) begin
      hib_latch <= 1'b0; // [R5]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Charge drive to the analog loops
  always @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_charge_drive    <= `DRV_OFF;
      o_drive_reduce    <= 1'b0;
      o_term_high_level <= 1'b0;
      o_test_pulse      <= 1'b0;
    end else begin
      o_term_high_level <= i_chemistry_select; // [R3]
      o_test_pulse      <= test_active && !i_charge_inhibit; // [R15]
      if (i_charge_inhibit) begin
        o_charge_drive <= `DRV_OFF; // [R1]
      end else if (test_active) begin
        o_charge_drive <= `DRV_FULL; // [R16]
      end else begin
        case (state)
          `ST_PRECHARGE: o_charge_drive <= `DRV_PRECHARGE; // [R12]
          `ST_FULL:      o_charge_drive <= `DRV_FULL; // [R13]
          `ST_TRICKLE:   o_charge_drive <= `DRV_CLAMP; // [R13]
          default:       o_charge_drive <= `DRV_OFF;
        endcase
      end
      // Power limit stays off during a test pulse so the supply can show full current
      o_drive_reduce <= i_excess_power && charging && !test_active && !i_charge_inhibit; // [R14]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Load switch
  always @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_load_switch_on <= 1'b0;
    end else begin
      // The debounced request opens the switch on the same edge that the latch catches it
      o_load_switch_on <= !load_fault && !hib_latch && !hib_db; // [R4] [R5] [R17]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status pins to the phone
  always @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_charger_seen_out     <= 1'b0;
      o_charger_seen_out_oe  <= 1'b0;
      o_charge_phase_flag    <= 1'b0;
      o_charge_phase_flag_oe <= 1'b0;
      o_phone_power_allow    <= 1'b0;
    end else begin
      o_charger_seen_out     <= 1'b0;
      o_charger_seen_out_oe  <= charger_seen; // [R7] [R8]
      o_charge_phase_flag    <= 1'b0;
      o_charge_phase_flag_oe <= charge_full; // [R9] [R10]
      o_phone_power_allow    <= i_cell_above_phone_on && charger_seen && !i_battery_present_n; // [R11]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status word for the register port
  always @* begin
    status_word                      = 8'h00;
    status_word[`STAT_STATE_LO +: 2] = state;
    status_word[`STAT_CHARGER]       = charger_seen;
    status_word[`STAT_HIB]           = hib_latch;
    status_word[`STAT_TEST]          = o_test_pulse;
    status_word[`STAT_LOAD]          = o_load_switch_on;
    status_word[`STAT_INHIBIT]       = i_charge_inhibit;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register port
  always @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      control   <= `CTRL_RESET;
      o_rd_data <= 8'h00;
    end else begin
      if (ctrl_write) begin
        control <= {7'h00, i_wr_data[`CTRL_TEST_EN]};
      end
      // Idle cycles and unmapped reads return zero
      o_rd_data <= 8'h00;
      if (i_rd) begin
        case (i_addr)
          `ADDR_STATUS:  o_rd_data <= status_word;
          `ADDR_CONTROL: o_rd_data <= control;
          default:       o_rd_data <= 8'h00;
        endcase
      end
    end
  end
endmodule // li_ion_charge_control_logic

/* test/phone_pm_model.sv */
// Phone side model of the open-drain status pins
`timescale 1ns/1ps
module phone_pm_model (
  // Open-drain pins from the device
  input  wire i_seen_data,
  input  wire i_seen_oe,
  input  wire i_phase_data,
  input  wire i_phase_oe,
  // Levels seen by the phone
  output wire o_seen_line,
  output wire o_phase_line
);
  // Released pins float up to the rail
  assign o_seen_line  = i_seen_oe ? i_seen_data : 1'b1;
  assign o_phase_line = i_phase_oe ? i_phase_data : 1'b1;
endmodule // phone_pm_model

/* test/charge_ctrl_assertions.sv */
// Checker bound to the charge supervisory logic
`timescale 1ns/1ps
module charge_ctrl_assertions #(
  parameter TICK_CYCLES   = 4,
  parameter TEST_WIDTH_MS = 8
) (
  input wire       i_sys_clk,
  input wire       i_sys_rst,
  input wire       i_charge_inhibit,
  input wire       i_battery_present_n,
  input wire       i_cell_above_phone_on,
  input wire       i_cell_above_charge_low,
  input wire       i_load_overload,
  input wire [1:0] o_charge_drive,
  input wire       o_drive_reduce,
  input wire       o_test_pulse,
  input wire       o_load_switch_on,
  input wire       o_charger_seen_out_oe,
  input wire       o_charge_phase_flag_oe,
  input wire       o_phone_power_allow
);
  localparam W = TICK_CYCLES * TEST_WIDTH_MS;
  reg [31:0] hi_cnt;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);
  // Cycles the current test pulse has been high
  always @(posedge i_sys_clk) begin
    if (i_sys_rst || !o_test_pulse) hi_cnt <= 32'h0;
    else hi_cnt <= hi_cnt + 32'h1;
  end
  ////////////////////////////////////////
  property p_inh; i_charge_inhibit [*3] |-> o_charge_drive == 2'h0; endproperty
  a_inh: assert property (p_inh) else $error("drive on while inhibited");
  property p_inh_flag; i_charge_inhibit [*3] |-> !o_charge_phase_flag_oe; endproperty
  a_inh_flag: assert property (p_inh_flag) else $error("flag low while inhibited");
  property p_bat; i_battery_present_n [*4] |-> !o_charger_seen_out_oe; endproperty
  a_bat: assert property (p_bat) else $error("charger seen without battery");
  property p_pwr; (!i_cell_above_phone_on || i_battery_present_n) |=> !o_phone_power_allow; endproperty
  a_pwr: assert property (p_pwr) else $error("power allow wrong");
  property p_flag; o_charge_phase_flag_oe |-> o_charge_drive == 2'h2; endproperty
  a_flag: assert property (p_flag) else $error("flag low outside full rate");
  property p_red; o_test_pulse && $past(o_test_pulse) |-> !o_drive_reduce; endproperty
  a_red: assert property (p_red) else $error("drive cut in test pulse");
  property p_width;
    $fell(o_test_pulse) && !$past(i_charge_inhibit) && $past(i_cell_above_phone_on) |->
      hi_cnt >= W - TICK_CYCLES && hi_cnt <= W + TICK_CYCLES;
  endproperty
  a_width: assert property (p_width) else $error("test pulse width wrong");
  property p_load; (i_load_overload || !i_cell_above_charge_low) [*2] |-> !o_load_switch_on; endproperty
  a_load: assert property (p_load) else $error("load switch closed on fault");
  c_pulse: cover property ($fell(o_test_pulse));
  c_clamp: cover property (o_charge_drive == 2'h3);
  c_seen: cover property ($rose(o_charger_seen_out_oe));
endmodule // charge_ctrl_assertions

bind li_ion_charge_control_logic charge_ctrl_assertions #(
  .TICK_CYCLES(TICK_CYCLES), .TEST_WIDTH_MS(TEST_WIDTH_MS)) i_chk (
  .i_sys_clk, .i_sys_rst, .i_charge_inhibit, .i_battery_present_n, .i_cell_above_phone_on,
  .i_cell_above_charge_low, .i_load_overload, .o_charge_drive, .o_drive_reduce, .o_test_pulse,
  .o_load_switch_on, .o_charger_seen_out_oe, .o_charge_phase_flag_oe, .o_phone_power_allow);

/* test/tb_top.sv */
// Self-checking bench for the charge supervisory logic
`timescale 1ns/1ps
module tb_top;
  localparam TK = 4, TW = 8, TP = 40, LOW = (TP - TW) * TK * 4;
  reg        clk = 0, rst = 1, inh = 0, chem = 0, hreq = 0, hx_n = 1, bat_n = 0, chg = 0;
  reg        pon = 1, clow = 1, tlo = 0, exc = 0, ovl = 0, wr_s = 0, rd_s = 0, rd_d = 0, pchk = 0;
  reg        pre = 1, thi = 0, uns = 0;
  reg  [1:0] addr = 0;
  reg  [7:0] wdat = 0;
  reg [31:0] seed = 32'h5117;
  reg [17:0] pq[$];
  reg [15:0] rq[$];
  reg [17:0] pe;
  reg [15:0] re;
  wire [1:0] drv;
  wire [7:0] rdat;
  wire       red, thl, tp, ld, sd, soe, pd, poe, ppa, sl, pl;
  wire [8:0] obs = {drv, red, thl, tp, ld, sl, pl, ppa};
  integer    failures = 0, tests_run = 0, k;
  time       t0;
  li_ion_charge_control_logic #(.TICK_CYCLES(TK), .DEBOUNCE_MS(4), .TEST_WIDTH_MS(TW), .TEST_PERIOD_MS(TP)) i_dut (
    .i_sys_clk(clk), .i_sys_rst(rst), .i_charge_inhibit(inh), .i_chemistry_select(chem),
    .i_hibernate_request(hreq), .i_hibernate_exit_n(hx_n), .i_battery_present_n(bat_n),
    .i_charger_sense(chg), .i_cell_above_precharge(pre), .i_cell_above_phone_on(pon),
    .i_cell_above_charge_low(clow), .i_cell_at_term_low(tlo), .i_cell_at_term_high(thi),
    .i_excess_power(exc), .i_pass_unsat(uns), .i_load_overload(ovl), .o_charge_drive(drv),
    .o_drive_reduce(red), .o_term_high_level(thl), .o_test_pulse(tp), .o_load_switch_on(ld),
    .o_charger_seen_out(sd), .o_charger_seen_out_oe(soe), .o_charge_phase_flag(pd),
    .o_charge_phase_flag_oe(poe), .o_phone_power_allow(ppa), .i_addr(addr), .i_wr_data(wdat),
    .i_wr(wr_s), .i_rd(rd_s), .o_rd_data(rdat));
  phone_pm_model i_pm (.i_seen_data(sd), .i_seen_oe(soe), .i_phase_data(pd), .i_phase_oe(poe),
    .o_seen_line(sl), .o_phase_line(pl));
  initial forever #2 clk = ~clk;
  function [31:0] xs(input [31:0] s); begin
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    xs = s ^ (s << 5);
  end endfunction
  task tick(input integer n); begin
    repeat (n) @(posedge clk);
  end endtask
  // Notes the masked pin pattern expected after n + 1 more cycles, checked on the next edge
  task chk(input integer n, input [8:0] m, input [8:0] e); begin
    tick(n + 1);
    pq.push_back({m, e});
    pchk <= 1;
    tick(1);
    pchk <= 0;
  end endtask
  task wr(input [1:0] a, input [7:0] d); begin
    tick(1);
    addr <= a;
    wdat <= d;
    wr_s <= 1;
    tick(1);
    wr_s <= 0;
  end endtask
  task rd(input [1:0] a, input [7:0] m, input [7:0] e); begin
    tick(1);
    addr <= a;
    rd_s <= 1;
    rq.push_back({m, e});
    tick(1);
    rd_s <= 0;
  end endtask
  task wait_tp(input v); begin
    for (k = 0; k < 400 && tp !== v; k = k + 1) @(posedge clk);
    if (tp !== v) begin
      failures = failures + 1;
      $display("mismatch %0t test pulse timeout", $time);
    end
  end endtask
  task finish_test; begin
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  end endtask
  // Compares each result with the oldest note
  always @(posedge clk) begin
    rd_d <= rd_s;
    if (pchk) begin
      pe = pq.pop_front();
      tests_run = tests_run + 1;
      if (((obs ^ pe[8:0]) & pe[17:9]) !== 9'h0) begin
        failures = failures + 1;
        $display("mismatch %0t pins %h", $time, obs);
      end
    end
    if (rd_d) begin
      re = rq.pop_front();
      tests_run = tests_run + 1;
      if (((rdat ^ re[7:0]) & re[15:8]) !== 8'h0) begin
        failures = failures + 1;
        $display("mismatch %0t read %h", $time, rdat);
      end
    end
  end
  initial begin
    #40000;
    failures = failures + 1;
    finish_test();
  end
  initial begin
    tick(2);
    rst <= 0;
    rd(1, 8'hff, 8'h01);
    repeat (4) begin
      seed = xs(seed);
      chem <= seed[0];
      chk(1, 9'h020, {3'h0, seed[0], 5'h0});
    end
    clow <= 0;
    chk(2, 9'h008, 9'h000);
    clow <= 1;
    hreq <= 1;
    chk(6, 9'h008, 9'h008);
    hreq <= 0;
    tick(1);
    hreq <= 1;
    chk(28, 9'h008, 9'h000);
    rd(0, 8'h08, 8'h08);
    hreq <= 0;
    chk(24, 9'h008, 9'h000);
    hx_n <= 0;
    tick(1);
    hx_n <= 1;
    chk(2, 9'h008, 9'h008);
    $display("load test done");
    bat_n <= 1;
    chg <= 1;
    chk(40, 9'h005, 9'h004);
    bat_n <= 0;
    chk(6, 9'h004, 9'h004);
    chk(24, 9'h187, 9'h101);
    rd(0, 8'h67, 8'h26);
    wait_tp(1);
    wait_tp(0);
    t0 = $time;
    wait_tp(1);
    tests_run = tests_run + 1;
    if ($time - t0 + 16 < LOW || $time - t0 > LOW + 16) begin
      failures = failures + 1;
      $display("mismatch %0t pulse period", $time);
    end
    exc <= 1;
    chk(3, 9'h050, 9'h010);
    wait_tp(0);
    chk(2, 9'h040, 9'h040);
    exc <= 0;
    chem <= 1;
    tlo <= 1;
    chk(2, 9'h182, 9'h100);
    chem <= 0;
    chk(2, 9'h182, 9'h182);
    tlo <= 0;
    thi <= 1;
    uns <= 1;
    wait_tp(1);
    wait_tp(0);
    chk(2, 9'h002, 9'h002);
    uns <= 0;
    wait_tp(1);
    wait_tp(0);
    chk(2, 9'h002, 9'h000);
    inh <= 1;
    chk(2, 9'h182, 9'h002);
    rd(0, 8'h40, 8'h40);
    inh <= 0;
    pre <= 0;
    chk(4, 9'h190, 9'h080);
    pre <= 1;
    chk(4, 9'h190, 9'h110);
    wait_tp(0);
    pon <= 0;
    chk(2, 9'h001, 9'h000);
    for (k = 0; k < 200 && tp !== 1'b1; k = k + 1) tick(1);
    chk(0, 9'h010, 9'h000);
    chg <= 0;
    chk(6, 9'h004, 9'h000);
    chk(16, 9'h004, 9'h004);
    $display("charge test done");
    wr(1, 8'h00);
    wr(2, 8'hff);
    rd(1, 8'hff, 8'h00);
    rd(2, 8'hff, 8'h00);
    rd(3, 8'hff, 8'h00);
    ovl <= 1;
    chk(2, 9'h008, 9'h000);
    $display("register test done");
    tick(2);
    finish_test();
  end
endmodule // tb_top
